//--- design/ddr2_cke_odt_ctl.sv
// Behaviour
// - CKE dropped asynchronously puts device in reset; contents lost; reinit restores operation.
// - In reset every input but CKE is ignored.
// - A read burst cut by reset may complete once CKE returns high.
// - ODT acts only after EMR enables it and the 12ns tMOD passes.
// - ODT category follows CKE state; ODT ignored in self refresh and right after enable.
// - Active and fast-exit power-down use synchronous ODT timing.
// - Slow-exit and precharge power-down use asynchronous ODT timing.
// - ODT fall before slow-exit or precharge power-down entry is synchronous only if tANPD met.
// - ODT rise before slow-exit or precharge power-down entry is synchronous only if tANPD met.
// - ODT fall after any power-down exit is synchronous only once tAXPD met.
// - ODT rise after slow or precharge exit is synchronous only once tAXPD met.
// - New termination from an EMR load applies within tMOD.
// - Nominal termination is taken from EMR address bits A6 and A2.
`timescale 1ns/1ps
`default_nettype none

module ddr2_cke_odt_ctl
	import ddr2_ckeodt_pkg::*;
(
	input  wire logic                          clk,
	input  wire logic                          rst,
	input  wire logic                          ce,
	input  wire logic                          cke,
	input  wire logic                          odt,
	input  wire logic [3:0]                    cmd,
	input  wire logic [2:0]                    ba,
	input  wire logic [13:0]                   addr,
	input  wire logic [ddr2_ckeodt_pkg::REG_AW-1:0] reg_addr,
	input  wire logic [ddr2_ckeodt_pkg::REG_DW-1:0] reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic      [ddr2_ckeodt_pkg::REG_DW-1:0] reg_rdata,
	output logic                               term_on,
	output logic      [1:0]                    rtt_sel,
	output logic                               odt_async,
	output ddr2_ckeodt_pkg::mode_e             mode,
	output logic                               contents_lost,
	output logic                               rd_burst_active
);
	import ddr2_ckeodt_pkg::*;

	// =========================================================
	// helpers
	function automatic logic is_idle_cmd(input logic [3:0] c);
		return c[3] || (c == CMD_NOP);
	endfunction

	function automatic logic [3:0] age_inc(input logic [3:0] a);
		return (a == AGE_SAT) ? AGE_SAT : a + 4'h1;
	endfunction

	function automatic logic is_async_pd(input mode_e m);
		return (m == M_PD_SLOW) || (m == M_PD_PRE);
	endfunction

	// =========================================================
	// state
	typedef struct packed {
		mode_e             mode;
		logic              cke_q;
		logic              odt_q;
		logic [7:0]        open_rows;
		logic              mr12;
		logic [2:0]        bl;
		logic              mr_done;
		logic              emr_done;
		logic [1:0]        rtt_pend;
		logic [1:0]        rtt;
		logic [1:0]        mod_cnt;
		logic              odt_ready;
		logic [3:0]        odt_age;
		logic              last_async;
		logic [3:0]        exit_age;
		logic              exit_slow;
		logic [2:0]        burst_cnt;
		logic              burst_rd;
		logic              rd_act;
		logic [3:0]        anpd;
		logic [3:0]        axpd;
		logic              ev_lost;
		logic              ev_ignored;
		logic              lost_pulse;
		logic [REG_DW-1:0] rdata;
		logic              req;
		logic              level;
		logic              async_mode;
	} ctl_s;

	localparam ctl_s RESET_S = '{
		mode: M_RESET, odt_age: AGE_SAT, exit_age: AGE_SAT,
		anpd: ANPD_RST, axpd: AXPD_RST, default: '0
	};

	ctl_s s;
	ctl_s n;

	odt_req_if oreq ();

	odt_timer u_timer (
		.clk (clk),
		.rst (rst),
		.ce  (ce),
		.bus (oreq.tmr)
	);

	assign oreq.req        = s.req;
	assign oreq.level      = s.level;
	assign oreq.async_mode = s.async_mode;

	assign reg_rdata       = s.rdata;
	assign term_on         = oreq.term_on;
	assign rtt_sel         = s.rtt;
	assign odt_async       = s.last_async;
	assign mode            = s.mode;
	assign contents_lost   = s.lost_pulse;
	assign rd_burst_active = s.rd_act;

	logic cke_fall;
	logic cke_rise;
	logic odt_edge;
	logic edge_async;
	logic [REG_DW-1:0] status_word;

	always_comb begin
		cke_fall = s.cke_q && !cke;
		cke_rise = !s.cke_q && cke;
		odt_edge = (odt != s.odt_q);

		status_word = '0;
		status_word[ST_MODE_LSB +: 3] = s.mode;
		status_word[ST_TERM]          = oreq.term_on;
		status_word[ST_ASYNC]         = s.last_async;
		status_word[ST_RTT_LSB +: 2]  = s.rtt;
		status_word[ST_READY]         = s.odt_ready;
		status_word[ST_BURST]         = s.burst_cnt != 3'h0;
		status_word[ST_OPEN_LSB +: 8] = s.open_rows;

		// timing category of an ODT change in the present cycle
		edge_async = is_async_pd(s.mode);
		if (s.mode == M_ACTIVE && s.exit_age < s.axpd) begin
			if (!odt) begin
				edge_async = 1'b1;
			end else if (s.exit_slow) begin
				edge_async = 1'b1;
			end
		end
	end

	// =========================================================
	// next state
	always_comb begin
		n = s;
		n.cke_q      = cke;
		n.req        = 1'b0;
		n.lost_pulse = 1'b0;
		n.rdata      = '0;
		n.odt_age    = age_inc(s.odt_age);
		n.exit_age   = age_inc(s.exit_age);

		// burst counting freezes in reset and resumes when CKE returns
		if (s.burst_cnt != 3'h0 && s.mode != M_RESET) begin
			n.burst_cnt = s.burst_cnt - 3'h1;
		end

		// termination value lands tMOD after the EMR load
		if (s.mod_cnt != 2'h0) begin
			n.mod_cnt = s.mod_cnt - 2'h1;
			if (s.mod_cnt == 2'h1) begin
				n.rtt       = s.rtt_pend;
				n.odt_ready = s.rtt_pend != 2'h0;
				n.odt_q     = 1'b0;
			end
		end

		case (s.mode)
			M_RESET: begin
				// only CKE is looked at here
				if (cke_rise) begin
					n.mode = M_INIT;
				end
			end
			M_INIT: begin
				if (cke_fall) begin
					n.mode       = M_RESET;
					n.ev_lost    = 1'b1;
					n.lost_pulse = 1'b1;
				end else if (cmd == CMD_LOAD && ba == BA_MR) begin
					n.mr12    = addr[A_PDX];
					n.bl      = addr[A_BL_LSB +: 3];
					n.mr_done = 1'b1;
				end else if (cmd == CMD_LOAD && ba == BA_EMR) begin
					n.rtt_pend = {addr[A_RTT_HI], addr[A_RTT_LO]};
					n.mod_cnt  = MOD_CYC;
					n.emr_done = 1'b1;
				end
				if (s.mr_done && s.emr_done) begin
					n.mode = M_ACTIVE;
				end
			end
			M_ACTIVE: begin
				if (cke_fall && (!is_idle_cmd(cmd) && cmd != CMD_REF
						|| s.burst_cnt != 3'h0)) begin
					// an unplanned drop: array contents and settings are gone
					n            = RESET_S;
					n.cke_q      = cke;
					n.anpd       = s.anpd;
					n.axpd       = s.axpd;
					n.ev_ignored = s.ev_ignored;
					n.burst_cnt  = s.burst_cnt;
					n.burst_rd   = s.burst_rd;
					n.ev_lost    = 1'b1;
					n.lost_pulse = 1'b1;
				end else if (cke_fall) begin
					if (cmd == CMD_REF) begin
						n.mode = M_SELF_REF;
					end else if (s.open_rows == 8'h00) begin
						n.mode = M_PD_PRE;
					end else begin
						n.mode = s.mr12 ? M_PD_SLOW : M_PD_FAST;
					end
					// a recent ODT change too close to slow-exit or precharge power-down entry becomes asynchronous
					if (cmd != CMD_REF && s.odt_ready && s.odt_age < s.anpd
							&& !s.last_async && s.mr12 | (s.open_rows == 8'h00)) begin
						n.req        = 1'b1;
						n.level      = s.odt_q;
						n.async_mode = 1'b1;
						n.last_async = 1'b1;
					end
				end else begin
					case (cmd)
						CMD_ACT: n.open_rows[ba] = 1'b1;
						CMD_PRE: begin
							if (addr[A_AP]) begin
								n.open_rows = 8'h00;
							end else begin
								n.open_rows[ba] = 1'b0;
							end
						end
						CMD_READ, CMD_WRITE: begin
							n.burst_cnt = (s.bl == BL8_CODE) ? BURST8_CYC : BURST4_CYC;
							n.burst_rd  = cmd == CMD_READ;
						end
						CMD_LOAD: begin
							if (ba == BA_MR) begin
								n.mr12 = addr[A_PDX];
								n.bl   = addr[A_BL_LSB +: 3];
							end else if (ba == BA_EMR) begin
								// controller keeps ODT low across this window
								n.rtt_pend  = {addr[A_RTT_HI], addr[A_RTT_LO]};
								n.mod_cnt   = MOD_CYC;
								n.odt_ready = 1'b0;
							end
						end
						default: ;
					endcase
				end
			end
			M_PD_FAST, M_PD_SLOW, M_PD_PRE: begin
				if (cke_rise) begin
					n.mode      = M_ACTIVE;
					n.exit_age  = 4'h0;
					n.exit_slow = s.mode != M_PD_FAST;
				end
			end
			M_SELF_REF: begin
				if (odt_edge) begin
					n.ev_ignored = 1'b1;
				end
				if (cke_rise) begin
					n.mode = M_ACTIVE;
				end
			end
			default: n.mode = M_RESET;
		endcase

		// ODT changes only count once termination is enabled and settled
		if (s.odt_ready && odt_edge && s.mode != M_SELF_REF && s.mode != M_RESET
				&& s.mode != M_INIT && n.mode != M_RESET) begin
			n.odt_q      = odt;
			n.odt_age    = 4'h0;
			n.req        = 1'b1;
			n.level      = odt;
			n.async_mode = edge_async;
			n.last_async = edge_async;
		end

		// register port
		if (reg_rd) begin
			case (reg_addr)
				REG_STATUS: n.rdata = status_word;
				REG_TIMING: begin
					n.rdata[TM_ANPD_LSB +: 4] = s.anpd;
					n.rdata[TM_AXPD_LSB +: 4] = s.axpd;
				end
				REG_EVENT: begin
					n.rdata[EV_LOST]    = s.ev_lost;
					n.rdata[EV_IGNORED] = s.ev_ignored;
				end
				default: n.rdata = '0;
			endcase
		end
		if (reg_wr) begin
			case (reg_addr)
				REG_TIMING: begin
					n.anpd = reg_wdata[TM_ANPD_LSB +: 4];
					n.axpd = reg_wdata[TM_AXPD_LSB +: 4];
				end
				REG_EVENT: begin
					// a new event in the same cycle survives the clear
					n.ev_lost    = n.ev_lost & ~(reg_wdata[EV_LOST] & ~n.lost_pulse);
					n.ev_ignored = n.ev_ignored
						& ~(reg_wdata[EV_IGNORED] & ~(s.mode == M_SELF_REF && odt_edge));
				end
				default: ;
			endcase
		end

		// registered copy so the pin comes straight from a flop
		n.rd_act = n.burst_rd && (n.burst_cnt != 3'h0);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= RESET_S;
		end else if (ce) begin
			s <= n;
		end
	end
endmodule

`default_nettype wire

//--- design/odt_timer.sv
`timescale 1ns/1ps
`default_nettype none

module odt_timer
	import ddr2_ckeodt_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic ce,
	odt_req_if.tmr    bus
);
	import ddr2_ckeodt_pkg::*;

	typedef struct packed {
		logic [2:0] cnt;
		logic       pend;
		logic       term_on;
	} tmr_s;

	tmr_s s;
	tmr_s n;

	assign bus.term_on = s.term_on;

	always_comb begin
		n = s;
		if (bus.req && bus.async_mode) begin
			// asynchronous category: termination follows at once, cancels a pending sync change
			n.term_on = bus.level;
			n.cnt     = 3'h0;
		end else if (bus.req) begin
			n.cnt  = bus.level ? AOND_CYC : AOFD_CYC;
			n.pend = bus.level;
		end else if (s.cnt != 3'h0) begin
			n.cnt = s.cnt - 3'h1;
			if (s.cnt == 3'h1) begin
				n.term_on = s.pend;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
		end else if (ce) begin
			s <= n;
		end
	end
endmodule

`default_nettype wire

//--- pkg/ddr2_ckeodt_pkg.sv
package ddr2_ckeodt_pkg;

	// =========================================================
	// register port
	localparam int unsigned REG_AW      = 4;
	localparam int unsigned REG_DW      = 32;
	localparam logic [3:0]  REG_STATUS  = 4'h0;
	localparam logic [3:0]  REG_TIMING  = 4'h4;
	localparam logic [3:0]  REG_EVENT   = 4'h8;

	// status fields
	localparam int unsigned ST_MODE_LSB = 0;
	localparam int unsigned ST_TERM     = 3;
	localparam int unsigned ST_ASYNC    = 4;
	localparam int unsigned ST_RTT_LSB  = 5;
	localparam int unsigned ST_READY    = 7;
	localparam int unsigned ST_BURST    = 8;
	localparam int unsigned ST_OPEN_LSB = 16;
	// timing fields and reset values, in clocks
	localparam int unsigned TM_ANPD_LSB = 0;
	localparam int unsigned TM_AXPD_LSB = 8;
	localparam logic [3:0]  ANPD_RST    = 4'h3;
	localparam logic [3:0]  AXPD_RST    = 4'h8;
	// event fields, write one to clear
	localparam int unsigned EV_LOST     = 0;
	localparam int unsigned EV_IGNORED  = 1;

	// =========================================================
	// timing
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned T_MOD_NS      = 12;
	localparam int unsigned MOD_CYC_I     = (T_MOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0]  MOD_CYC       = (MOD_CYC_I < 1) ? 2'h1 : MOD_CYC_I[1:0];
	localparam logic [2:0]  AOND_CYC      = 3'h2;
	localparam logic [2:0]  AOFD_CYC      = 3'h2;
	localparam logic [3:0]  AGE_SAT       = 4'hf;
	localparam logic [2:0]  BURST4_CYC    = 3'h2;
	localparam logic [2:0]  BURST8_CYC    = 3'h4;
	localparam logic [2:0]  BL8_CODE      = 3'h3;

	// =========================================================
	// address bits carried by mode loads and precharge
	localparam int unsigned A_BL_LSB = 0;
	localparam int unsigned A_RTT_LO = 2;
	localparam int unsigned A_RTT_HI = 6;
	localparam int unsigned A_AP     = 10;
	localparam int unsigned A_PDX    = 12;
	localparam logic [2:0]  BA_MR    = 3'h0;
	localparam logic [2:0]  BA_EMR   = 3'h1;

	// commands as {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_NOP   = 4'h7;
	localparam logic [3:0] CMD_READ  = 4'h5;
	localparam logic [3:0] CMD_WRITE = 4'h4;
	localparam logic [3:0] CMD_ACT   = 4'h3;
	localparam logic [3:0] CMD_PRE   = 4'h2;
	localparam logic [3:0] CMD_REF   = 4'h1;
	localparam logic [3:0] CMD_LOAD  = 4'h0;

	typedef enum logic [2:0] {
		M_RESET    = 3'b000,
		M_INIT     = 3'b001,
		M_ACTIVE   = 3'b010,
		M_PD_FAST  = 3'b011,
		M_PD_SLOW  = 3'b100,
		M_PD_PRE   = 3'b101,
		M_SELF_REF = 3'b110
	} mode_e;

endpackage

//--- pkg/odt_req_if.sv
`timescale 1ns/1ps
`default_nettype none

interface odt_req_if;
	logic req;
	logic level;
	logic async_mode;
	logic term_on;

	modport ctl (output req, output level, output async_mode, input term_on);
	modport tmr (input req, input level, input async_mode, output term_on);
endinterface

`default_nettype wire

//--- test/ddr2_cke_odt_ctl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module ddr2_cke_odt_ctl_tb_top;
	import ddr2_ckeodt_pkg::*;

	logic              clk;
	logic              rst;
	logic              ce;
	logic              cke;
	logic              odt;
	logic [3:0]        cmd;
	logic [2:0]        ba;
	logic [13:0]       addr;
	logic [REG_AW-1:0] reg_addr;
	logic [REG_DW-1:0] reg_wdata;
	logic              reg_wr;
	logic              reg_rd;
	logic [REG_DW-1:0] reg_rdata;
	logic              term_on;
	logic [1:0]        rtt_sel;
	logic              odt_async;
	mode_e             mode;
	logic              contents_lost;
	logic              rd_burst_active;
	int                n_errors;
	int                compares;

	ddr2_cke_odt_ctl u_ddr2_cke_odt_ctl (
		.clk             (clk),
		.rst             (rst),
		.ce              (ce),
		.cke             (cke),
		.odt             (odt),
		.cmd             (cmd),
		.ba              (ba),
		.addr            (addr),
		.reg_addr        (reg_addr),
		.reg_wdata       (reg_wdata),
		.reg_wr          (reg_wr),
		.reg_rd          (reg_rd),
		.reg_rdata       (reg_rdata),
		.term_on         (term_on),
		.rtt_sel         (rtt_sel),
		.odt_async       (odt_async),
		.mode            (mode),
		.contents_lost   (contents_lost),
		.rd_burst_active (rd_burst_active)
	);
	mem_ctl_model u_mem_ctl_model (
		.clk  (clk),
		.cke  (cke),
		.odt  (odt),
		.cmd  (cmd),
		.ba   (ba),
		.addr (addr)
	);

	// =========================================================
	// helpers
	initial begin
		clk = 1'b0;
		// the clock never stops, so the hold after an unplanned cke drop is always kept
		forever #12.5 clk = ~clk;
	end

	task automatic end_sim;
		if (n_errors == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk(reg_rdata, exp);
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic mchk(input mode_e m);
		@(negedge clk);
		chk({29'h0, mode}, {29'h0, m});
	endtask

	task automatic pd(input logic k);
		u_mem_ctl_model.issue(k, CMD_NOP, 3'h0, 14'h0);
	endtask

	// sync change lands two clocks (turn-on/off delay) after the async one would
	task automatic odt_go(input logic v, input logic sync);
		u_mem_ctl_model.set_odt(v);
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk({31'h0, odt_async}, {31'h0, ~sync});
		chk({31'h0, term_on}, {31'h0, sync ? ~v : v});
		if (sync) begin
			@(posedge clk);
			@(negedge clk);
			chk({31'h0, term_on}, {31'h0, ~v});
			@(posedge clk);
			@(negedge clk);
			chk({31'h0, term_on}, {31'h0, v});
		end
	endtask

	// =========================================================
	// tests
	initial begin
		repeat (3000) @(posedge clk);
		n_errors++;
		end_sim();
	end

	initial begin
		rst = 1'b1;
		ce = 1'b1;
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		n_errors = 0;
		compares = 0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(REG_TIMING, 32'h0000_0803);
		rd(REG_EVENT, 32'h0);
		wr(REG_TIMING, 32'hffff_ffff);
		rd(REG_TIMING, 32'h0000_0f0f);
		wr(REG_TIMING, 32'h0000_0803);
		wr(4'hc, 32'hffff_ffff);
		rd(4'hc, 32'h0);
		u_mem_ctl_model.bring_up(14'h0040);
		mchk(M_ACTIVE);
		chk({30'h0, rtt_sel}, 32'h2);
		rd(REG_STATUS, 32'h0000_00c2);
		odt_go(1'b1, 1'b1);
		u_mem_ctl_model.idle(4);
		pd(1'b0);
		mchk(M_PD_PRE);
		odt_go(1'b0, 1'b0);
		pd(1'b1);
		mchk(M_ACTIVE);
		odt_go(1'b1, 1'b0);
		u_mem_ctl_model.idle(10);
		odt_go(1'b0, 1'b1);
		odt_go(1'b1, 1'b1);
		u_mem_ctl_model.idle(4);
		pd(1'b0);
		pd(1'b1);
		odt_go(1'b0, 1'b0);
		u_mem_ctl_model.idle(10);
		u_mem_ctl_model.set_odt(1'b1);
		pd(1'b0);
		u_mem_ctl_model.idle(2);
		mchk(M_PD_PRE);
		chk({31'h0, odt_async}, 32'h1);
		chk({31'h0, term_on}, 32'h1);
		pd(1'b1);
		u_mem_ctl_model.idle(10);
		odt_go(1'b0, 1'b1);
		u_mem_ctl_model.idle(4);
		u_mem_ctl_model.issue(1'b0, CMD_REF, 3'h0, 14'h0);
		mchk(M_SELF_REF);
		u_mem_ctl_model.set_odt(1'b1);
		u_mem_ctl_model.idle(5);
		@(negedge clk);
		chk({31'h0, term_on}, 32'h0);
		rd(REG_EVENT, 32'h2);
		u_mem_ctl_model.set_odt(1'b0);
		u_mem_ctl_model.idle(2);
		wr(REG_EVENT, 32'h3);
		rd(REG_EVENT, 32'h0);
		pd(1'b1);
		mchk(M_ACTIVE);
		u_mem_ctl_model.issue(1'b1, CMD_ACT, 3'h2, 14'h0010);
		u_mem_ctl_model.issue(1'b1, CMD_READ, 3'h2, 14'h0000);
		u_mem_ctl_model.issue(1'b0, CMD_READ, 3'h2, 14'h0000);
		mchk(M_RESET);
		chk({31'h0, contents_lost}, 32'h1);
		u_mem_ctl_model.issue(1'b0, CMD_LOAD, BA_EMR, 14'h0004);
		u_mem_ctl_model.idle(2);
		mchk(M_RESET);
		chk({30'h0, rtt_sel}, 32'h0);
		rd(REG_EVENT, 32'h1);
		pd(1'b1);
		mchk(M_INIT);
		chk({31'h0, rd_burst_active}, 32'h1);
		u_mem_ctl_model.bring_up(14'h0004);
		mchk(M_ACTIVE);
		chk({30'h0, rtt_sel}, 32'h1);
		// a low clock enable must swallow a register write
		@(posedge clk);
		ce <= 1'b0;
		wr(REG_TIMING, 32'h0000_0505);
		mchk(M_ACTIVE);
		@(posedge clk);
		ce <= 1'b1;
		rd(REG_TIMING, 32'h0000_0803);
		wr(REG_TIMING, 32'h0000_0505);
		rd(REG_TIMING, 32'h0000_0505);
		// second reset in mid-run: settings and events back to reset values
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		mchk(M_RESET);
		chk({30'h0, rtt_sel}, 32'h0);
		chk({31'h0, term_on}, 32'h0);
		rd(REG_TIMING, 32'h0000_0803);
		rd(REG_EVENT, 32'h0);
		mchk(M_INIT);
		end_sim();
	end
endmodule

`default_nettype wire

//--- test/ddr2_cke_odt_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module ddr2_cke_odt_monitor (
	input wire logic                                clk,
	input wire logic                                rst,
	input wire logic                                ce,
	input wire logic                                cke,
	input wire logic                                odt,
	input wire logic [3:0]                          cmd,
	input wire logic [2:0]                          ba,
	input wire logic [13:0]                         addr,
	input wire logic [ddr2_ckeodt_pkg::REG_AW-1:0] reg_addr,
	input wire logic [ddr2_ckeodt_pkg::REG_DW-1:0] reg_wdata,
	input wire logic                                reg_wr,
	input wire logic                                reg_rd,
	input wire logic [ddr2_ckeodt_pkg::REG_DW-1:0] reg_rdata,
	input wire logic                                term_on,
	input wire logic [1:0]                          rtt_sel,
	input wire logic                                odt_async,
	input wire ddr2_ckeodt_pkg::mode_e              mode,
	input wire logic                                contents_lost,
	input wire logic                                rd_burst_active
);
	import ddr2_ckeodt_pkg::*;

	// =========================================================
	// setup
	// a frozen clock enable stalls every counter, so checks pause with it
	default clocking @(posedge clk); endclocking
	default disable iff (rst || !ce);

	sequence s_drop;
		(mode == M_ACTIVE && cke) ##1 (!cke && cmd == CMD_READ);
	endsequence

	sequence s_emr;
		cke && mode != M_RESET && cmd == CMD_LOAD && ba == BA_EMR;
	endsequence

	// =========================================================
	// checks
	a_drop_reset: assert property (s_drop |=> mode == M_RESET && contents_lost)
		else $error("cke drop did not reset");
	a_lost_pulse: assert property (contents_lost |=> !contents_lost)
		else $error("lost pulse too long");
	a_reset_hold: assert property (mode == M_RESET && !cke |=> mode == M_RESET)
		else $error("left reset without cke");
	a_wake_init: assert property (mode == M_RESET && cke |=> mode == M_INIT)
		else $error("no init after cke rise");
	a_pd_async: assert property ((mode == M_PD_SLOW || mode == M_PD_PRE) &&
		$past(mode) == mode && $changed(term_on) |-> odt_async)
		else $error("sync odt in slow power-down");
	a_selfref_hold: assert property ((mode == M_SELF_REF)[*4] |-> $stable(term_on))
		else $error("odt acted in self refresh");
	a_rtt_emr: assert property (s_emr |-> ##2 rtt_sel ==
		{$past(addr[A_RTT_HI], 2), $past(addr[A_RTT_LO], 2)})
		else $error("rtt not taken from load");
	a_tmod_quiet: assert property (s_emr ##0 !term_on |=> (!term_on)[*3])
		else $error("termination during update");
	// odt first seen at one edge, request flop, timer load, two timer counts
	a_sync_rise: assert property ($rose(term_on) && !odt_async |->
		$past(odt, 1) && $past(odt, 2) && $past(odt, 3) && $past(odt, 4) && !$past(odt, 5))
		else $error("sync turn-on delay wrong");
endmodule

bind ddr2_cke_odt_ctl ddr2_cke_odt_monitor u_ddr2_cke_odt_monitor (
	.clk             (clk),
	.rst             (rst),
	.ce              (ce),
	.cke             (cke),
	.odt             (odt),
	.cmd             (cmd),
	.ba              (ba),
	.addr            (addr),
	.reg_addr        (reg_addr),
	.reg_wdata       (reg_wdata),
	.reg_wr          (reg_wr),
	.reg_rd          (reg_rd),
	.reg_rdata       (reg_rdata),
	.term_on         (term_on),
	.rtt_sel         (rtt_sel),
	.odt_async       (odt_async),
	.mode            (mode),
	.contents_lost   (contents_lost),
	.rd_burst_active (rd_burst_active)
);

`default_nettype wire

//--- test/mem_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none

module mem_ctl_model (
	input  wire logic        clk,
	output var  logic        cke,
	output var  logic        odt,
	output var  logic [3:0]  cmd,
	output var  logic [2:0]  ba,
	output var  logic [13:0] addr
);
	import ddr2_ckeodt_pkg::*;

	// =========================================================
	// pins
	// cke starts low so the device waits in reset until clocks run
	initial begin
		cke = 1'b0;
		odt = 1'b0;
		cmd = CMD_NOP;
		ba = 3'h0;
		addr = 14'h0;
	end

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic set_odt(input logic v);
		@(posedge clk);
		odt <= v;
	endtask

	// address lines flip after a command so stale values never look valid
	task automatic issue(input logic k, input logic [3:0] c, input logic [2:0] b,
		input logic [13:0] a);
		@(posedge clk);
		cke <= k;
		cmd <= c;
		ba <= b;
		addr <= a;
		@(posedge clk);
		cmd <= CMD_NOP;
		ba <= ~b;
		addr <= ~a;
	endtask

	task automatic bring_up(input logic [13:0] emr);
		@(posedge clk);
		odt <= 1'b0;
		cke <= 1'b1;
		cmd <= CMD_NOP;
		issue(1'b1, CMD_LOAD, BA_MR, 14'h1003);
		issue(1'b1, CMD_LOAD, BA_EMR, emr);
		idle(3);
	endtask
endmodule

`default_nettype wire
